// ### hw/ias_sequencer.sv
// Instruction address sequencer with its memory, tape loader and drum stepping.
// Operation
// - The counter is ten bits and covers every word address from 000 to 3FF.
// - In normal running the counter holds the address of the next word to fetch.
// - A transfer loads its address field into the counter.
// - The counter carries no left or right half selection; other logic does.
// - While stopped, the set-counter switch loads the selector switch value.
// - Ten display outputs always show the counter contents.
// - A drum instruction steps the counter through fifty memory addresses.
// - During tape loading the counter addresses the word that comes next.
// - The memory-clear switch sets every memory word to zero.
// - Loaded words go to successive addresses from the preset counter value.
// - When loading ends the counter returns to its starting address.
// - Loading ends when the reader delivers two adjacent spaces.
// - After the right-hand instruction completes the counter advances by one.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
module ias_sequencer import ias_pkg::*; (
  input  logic              clk,             // System clock, 10 MHz.
  input  logic              srst,            // Synchronous reset.
  input  logic [AXI_AW-1:0] s_axi_awaddr,    // AXI write address.
  input  logic              s_axi_awvalid,   // AXI write address valid.
  output logic              s_axi_awready,   // AXI write address ready.
  input  logic [31:0]       s_axi_wdata,     // AXI write data.
  input  logic [3:0]        s_axi_wstrb,     // AXI write strobes.
  input  logic              s_axi_wvalid,    // AXI write data valid.
  output logic              s_axi_wready,    // AXI write data ready.
  output logic [1:0]        s_axi_bresp,     // AXI write response.
  output logic              s_axi_bvalid,    // AXI write response valid.
  input  logic              s_axi_bready,    // AXI write response ready.
  input  logic [AXI_AW-1:0] s_axi_araddr,    // AXI read address.
  input  logic              s_axi_arvalid,   // AXI read address valid.
  output logic              s_axi_arready,   // AXI read address ready.
  output logic [31:0]       s_axi_rdata,     // AXI read data.
  output logic [1:0]        s_axi_rresp,     // AXI read response.
  output logic              s_axi_rvalid,    // AXI read valid.
  input  logic              s_axi_rready,    // AXI read ready.
  input  logic [ADDR_W-1:0] sel_sw,          // Address selector switches.
  input  logic              set_counter_sw,  // Set-counter switch.
  input  logic              mem_clear_sw,    // Memory-clear switch.
  input  logic              load_sw,         // Load switch, high when up.
  input  logic              reader_strobe,   // Reader character strobe.
  input  logic [4:0]        reader_char,     // Reader holes, bit 4 space.
  input  logic              machine_stopped, // Control is stopped.
  input  logic              xfer_valid,      // Transfer executes now.
  input  logic [ADDR_W-1:0] xfer_addr,       // Transfer address field.
  input  logic              advance_req,     // Right-hand order finished.
  input  logic              fetch_req,       // Fetch next word request.
  input  logic              drum_start,      // Drum instruction begins.
  input  logic              drum_step,       // Drum moves one word.
  input  logic              drum_wr,         // Drum word goes to memory.
  input  logic [WORD_W-1:0] drum_wdata,      // Word from the drum.
  output logic [ADDR_W-1:0] counter_lights,  // Counter display lights.
  output logic [WORD_W-1:0] instruction_holding_register, // Fetched word.
  output logic              ihr_valid,       // Fetched word is new.
  output logic [WORD_W-1:0] drum_rdata,      // Word for the drum.
  output logic              drum_done,       // Drum transfer finished.
  output logic              load_active,     // Tape loading under way.
  output logic              mem_clearing     // Memory clear under way.
);

  ias_mode_e         mode;
  ias_mode_e         next_mode;
  logic [ADDR_W-1:0] counter;
  logic [ADDR_W-1:0] save_addr;
  logic [ADDR_W-1:0] clr_addr;
  logic [5:0]        drum_cnt;
  logic [3:0]        nib_cnt;
  logic [35:0]       word_sr;
  logic              prev_space;
  logic              set_prev;
  logic              clr_prev;
  logic              load_prev;
  logic              strb_prev;
  logic              panel_en;
  logic [ADDR_W-1:0] peek_addr;
  logic [WORD_W-1:0] peek_word;
  logic [WORD_W-1:0] mem [DEPTH];
  logic [PANEL_W-1:0] panel_q;
  logic [RDR_W-1:0]   rdr_q;
  logic              reg_wr;
  logic [AXI_AW-1:0] reg_waddr;
  logic [31:0]       reg_wdata;
  logic [3:0]        reg_wstrb;
  logic [AXI_AW-1:0] reg_raddr;
  logic [31:0]       status_word;
  logic              wr_ok;
  logic              rd_ok;
  logic [31:0]       rd_data;

  ias_sync2 #(.W(PANEL_W)) u_panel_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({sel_sw, set_counter_sw, mem_clear_sw, load_sw}),
    .q    (panel_q)
  );

  ias_sync2 #(.W(RDR_W)) u_reader_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({reader_strobe, reader_char}),
    .q    (rdr_q)
  );

  wire [ADDR_W-1:0] sel_val  = panel_q[PANEL_W-1:3];
  wire              set_rise = panel_q[2] & ~set_prev & panel_en;
  wire              clr_rise = panel_q[1] & ~clr_prev & panel_en;
  wire              load_lvl = panel_q[0];
  wire              load_rise = load_lvl & ~load_prev & panel_en;
  wire              is_space = rdr_q[SPACE_BIT];

  wire idle       = (mode == MODE_RUN);
  wire loading    = (mode == MODE_LOAD);
  wire drumming   = (mode == MODE_DRUM);
  wire clearing   = (mode == MODE_CLEAR);
  wire char_take  = loading & rdr_q[RDR_W-1] & ~strb_prev;
  wire load_start = idle & load_rise & machine_stopped;
  wire dbl_space  = char_take & is_space & prev_space;
  // Dropping the load switch early also ends the load, so it cannot hang.
  wire load_end   = loading & (dbl_space | ~load_lvl);
  wire word_done  = char_take & ~is_space & (nib_cnt == CHAR_LAST);
  wire drum_begin = idle & drum_start & ~load_start;
  wire drum_go    = drumming & drum_step;
  wire drum_last  = drum_go & (drum_cnt == DRUM_LAST);
  wire clr_begin  = idle & clr_rise & ~load_start & ~drum_start;
  wire clr_last   = clearing & (clr_addr == ADDR_HIGH);
  wire xfer_take  = idle & xfer_valid;
  wire adv_take   = idle & advance_req & ~xfer_valid;
  wire set_take   = idle & set_rise & machine_stopped & ~xfer_valid
                    & ~advance_req;
  wire fetch_take = idle & fetch_req;

  // Plain ten-bit sum, so 3FF rolls over to 000.
  wire [ADDR_W-1:0] count_inc = counter + ADDR_ONE;

  // The counter holds a word address only; half selection lives elsewhere.
  wire [ADDR_W-1:0] next_counter =
    (load_end | drum_last) ? save_addr :
    (word_done | drum_go)  ? count_inc :
    xfer_take              ? xfer_addr :
    adv_take               ? count_inc :
    set_take               ? sel_val   :
    counter;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_RUN: begin
        if (load_start) begin
          next_mode = MODE_LOAD;
        end else if (drum_begin) begin
          next_mode = MODE_DRUM;
        end else if (clr_begin) begin
          next_mode = MODE_CLEAR;
        end
      end
      MODE_LOAD: begin
        if (load_end) begin
          next_mode = MODE_RUN;
        end
      end
      MODE_DRUM: begin
        if (drum_last) begin
          next_mode = MODE_RUN;
        end
      end
      MODE_CLEAR: begin
        if (clr_last) begin
          next_mode = MODE_RUN;
        end
      end
    endcase
  end

  wire              mem_we    = clearing | word_done | (drum_go & drum_wr);
  wire [ADDR_W-1:0] mem_waddr = clearing ? clr_addr : counter;
  wire [WORD_W-1:0] mem_wdata = clearing  ? WORD_ZERO :
                                word_done ? {word_sr, rdr_q[3:0]} :
                                drum_wdata;

  always_ff @(posedge clk) begin
    if (srst) begin
      mode    <= MODE_RUN;
      counter <= ADDR_LOW;
    end else begin
      mode    <= next_mode;
      counter <= next_counter;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      set_prev  <= 1'b0;
      clr_prev  <= 1'b0;
      load_prev <= 1'b0;
      strb_prev <= 1'b0;
      save_addr <= ADDR_LOW;
      drum_cnt  <= '0;
      clr_addr  <= ADDR_LOW;
      drum_done <= 1'b0;
    end else begin
      set_prev  <= panel_q[2];
      clr_prev  <= panel_q[1];
      load_prev <= load_lvl;
      strb_prev <= rdr_q[RDR_W-1];
      drum_done <= drum_last;
      if (load_start || drum_begin) begin
        save_addr <= counter;
      end
      if (drum_begin) begin
        drum_cnt <= '0;
      end else if (drum_go) begin
        drum_cnt <= drum_cnt + 6'h01;
      end
      if (clr_begin) begin
        clr_addr <= ADDR_LOW;
      end else if (clearing) begin
        clr_addr <= clr_addr + ADDR_ONE;
      end
    end
  end

  // A lone space separates words; only a second one in a row ends the load.
  always_ff @(posedge clk) begin
    if (srst || load_start) begin
      nib_cnt    <= '0;
      word_sr    <= '0;
      prev_space <= 1'b0;
    end else if (char_take) begin
      prev_space <= is_space;
      if (!is_space) begin
        word_sr <= {word_sr[31:0], rdr_q[3:0]};
        nib_cnt <= word_done ? 4'h0 : nib_cnt + 4'h1;
      end
    end
  end

  // The memory itself is not reset; the clear sweep zeroes it.
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      instruction_holding_register <= WORD_ZERO;
      ihr_valid  <= 1'b0;
      drum_rdata <= WORD_ZERO;
      peek_word  <= WORD_ZERO;
    end else begin
      ihr_valid <= fetch_take;
      if (fetch_take) begin
        instruction_holding_register <= mem[counter];
      end
      if (drum_go && !drum_wr) begin
        drum_rdata <= mem[counter];
      end
      peek_word <= mem[peek_addr];
    end
  end

  assign counter_lights = counter;
  assign load_active    = loading;
  assign mem_clearing   = clearing;

  ias_axil_slave u_axil (
    .clk       (clk),
    .srst      (srst),
    .s_awaddr  (s_axi_awaddr),
    .s_awvalid (s_axi_awvalid),
    .s_awready (s_axi_awready),
    .s_wdata   (s_axi_wdata),
    .s_wstrb   (s_axi_wstrb),
    .s_wvalid  (s_axi_wvalid),
    .s_wready  (s_axi_wready),
    .s_bresp   (s_axi_bresp),
    .s_bvalid  (s_axi_bvalid),
    .s_bready  (s_axi_bready),
    .s_araddr  (s_axi_araddr),
    .s_arvalid (s_axi_arvalid),
    .s_arready (s_axi_arready),
    .s_rdata   (s_axi_rdata),
    .s_rresp   (s_axi_rresp),
    .s_rvalid  (s_axi_rvalid),
    .s_rready  (s_axi_rready),
    .reg_wr    (reg_wr),
    .reg_waddr (reg_waddr),
    .reg_wdata (reg_wdata),
    .reg_wstrb (reg_wstrb),
    .wr_ok     (wr_ok),
    .reg_raddr (reg_raddr),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok)
  );

  wire wr_ctrl = reg_wr & (reg_waddr == REG_CTRL);
  wire wr_peek = reg_wr & (reg_waddr == REG_PEEK_ADDR);
  assign wr_ok = (reg_waddr == REG_CTRL) | (reg_waddr == REG_PEEK_ADDR);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_LOADING_BIT]  = loading;
    status_word[STAT_CLEARING_BIT] = clearing;
    status_word[STAT_DRUM_BIT]     = drumming;
    status_word[STAT_STOPPED_BIT]  = machine_stopped;
  end

  wire sel_cnt  = (reg_raddr == REG_COUNTER);
  wire sel_stat = (reg_raddr == REG_STATUS);
  wire sel_ctrl = (reg_raddr == REG_CTRL);
  wire sel_pka  = (reg_raddr == REG_PEEK_ADDR);
  wire sel_plo  = (reg_raddr == REG_PEEK_LO);
  wire sel_phi  = (reg_raddr == REG_PEEK_HI);
  assign rd_ok = sel_cnt | sel_stat | sel_ctrl | sel_pka | sel_plo | sel_phi;
  assign rd_data =
    sel_cnt  ? {22'h00_0000, counter} :
    sel_stat ? status_word :
    sel_ctrl ? {31'h0000_0000, panel_en} :
    sel_pka  ? {22'h00_0000, peek_addr} :
    sel_plo  ? peek_word[31:0] :
    sel_phi  ? {24'h00_0000, peek_word[WORD_W-1:32]} :
    32'h0000_0000;

  always_ff @(posedge clk) begin
    if (srst) begin
      panel_en  <= CTRL_PANEL_EN_RESET;
      peek_addr <= PEEK_ADDR_RESET;
    end else begin
      if (wr_ctrl && reg_wstrb[0]) begin
        panel_en <= reg_wdata[CTRL_PANEL_EN_BIT];
      end
      if (wr_peek && reg_wstrb[0]) begin
        peek_addr[7:0] <= reg_wdata[7:0];
      end
      if (wr_peek && reg_wstrb[1]) begin
        peek_addr[ADDR_W-1:8] <= reg_wdata[ADDR_W-1:8];
      end
    end
  end

  a_wrap_to_low:
  assert property (@(posedge clk) disable iff (srst)
    adv_take && counter == ADDR_HIGH |=> counter == ADDR_LOW)
    else $error("Counter did not wrap from the top address.");

  a_xfer_loads:
  assert property (@(posedge clk) disable iff (srst)
    xfer_take |=> counter == $past(xfer_addr))
    else $error("Transfer address not loaded into counter.");

  a_panel_set:
  assert property (@(posedge clk) disable iff (srst)
    set_take |=> counter == $past(sel_val) && counter_lights == counter)
    else $error("Selector value not loaded by set-counter.");

  a_fetch_from_counter:
  assert property (@(posedge clk) disable iff (srst)
    fetch_take |=> ihr_valid
      && instruction_holding_register == mem[$past(counter)])
    else $error("Fetched word not taken from counter address.");

  a_drum_step_count:
  assert property (@(posedge clk) disable iff (srst)
    drum_go && !drum_last |=> counter == $past(count_inc) && drumming)
    else $error("Drum step did not advance the counter.");

  a_drum_fifty_end:
  assert property (@(posedge clk) disable iff (srst)
    drum_last |=> idle && drum_done && counter == $past(save_addr))
    else $error("Drum transfer did not end after its last step.");

  a_load_successive:
  assert property (@(posedge clk) disable iff (srst)
    word_done && !load_end |-> mem_we && mem_waddr == counter
      ##1 counter == $past(count_inc))
    else $error("Loaded word not placed at successive address.");

  a_load_restore:
  assert property (@(posedge clk) disable iff (srst)
    load_end |=> counter == $past(save_addr) && idle)
    else $error("Counter not restored after loading.");

  a_two_spaces_end:
  assert property (@(posedge clk) disable iff (srst)
    dbl_space |=> idle && !load_active)
    else $error("Two adjacent spaces did not end loading.");

  a_clear_sweep:
  assert property (@(posedge clk) disable iff (srst)
    clr_begin |=> clearing && clr_addr == ADDR_LOW && mem_we
      && mem_wdata == WORD_ZERO ##1 clr_addr == ADDR_ONE)
    else $error("Memory clear sweep did not start at zero.");

endmodule // ias_sequencer

// ### hw/ias_pkg.sv
// Constants, register map and mode encoding of the instruction address sequencer.
package ias_pkg;

  localparam int unsigned ADDR_W  = 10;
  localparam int unsigned WORD_W  = 40;
  localparam int unsigned DEPTH   = 1024;
  localparam int unsigned AXI_AW  = 8;
  localparam int unsigned PANEL_W = 13;
  localparam int unsigned RDR_W   = 6;

  localparam logic [ADDR_W-1:0] ADDR_LOW   = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_HIGH  = 10'h3ff;
  localparam logic [ADDR_W-1:0] ADDR_ONE   = 10'h001;
  localparam logic [WORD_W-1:0] WORD_ZERO  = 40'h00_0000_0000;

  // Words moved by one drum instruction, and the index of the last one.
  localparam logic [5:0] DRUM_WORDS = 6'h32;
  localparam logic [5:0] DRUM_LAST  = DRUM_WORDS - 6'h01;

  // A memory word arrives from the reader as ten four-bit characters.
  localparam logic [3:0] CHAR_LAST  = 4'h9;
  localparam int unsigned SPACE_BIT = 4;

  localparam logic [AXI_AW-1:0] REG_COUNTER   = 8'h00;
  localparam logic [AXI_AW-1:0] REG_STATUS    = 8'h04;
  localparam logic [AXI_AW-1:0] REG_CTRL      = 8'h08;
  localparam logic [AXI_AW-1:0] REG_PEEK_ADDR = 8'h0c;
  localparam logic [AXI_AW-1:0] REG_PEEK_LO   = 8'h10;
  localparam logic [AXI_AW-1:0] REG_PEEK_HI   = 8'h14;

  localparam int unsigned STAT_LOADING_BIT  = 0;
  localparam int unsigned STAT_CLEARING_BIT = 1;
  localparam int unsigned STAT_DRUM_BIT     = 2;
  localparam int unsigned STAT_STOPPED_BIT  = 3;
  localparam int unsigned CTRL_PANEL_EN_BIT = 0;

  localparam logic              CTRL_PANEL_EN_RESET = 1'h1;
  localparam logic [ADDR_W-1:0] PEEK_ADDR_RESET     = 10'h000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_LOAD  = 2'b01,
    MODE_DRUM  = 2'b10,
    MODE_CLEAR = 2'b11
  } ias_mode_e;

endpackage

// ### hw/ias_sync2.sv
// Two-flop synchroniser for panel and reader pins.
module ias_sync2 #(
  parameter int unsigned W = 1
) (
  input  logic         clk,   // System clock.
  input  logic         srst,  // Synchronous reset.
  input  logic [W-1:0] d,     // Asynchronous pin levels.
  output logic [W-1:0] q      // Synchronised levels.
);

  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // ias_sync2

// ### hw/ias_axil_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes.
module ias_axil_slave import ias_pkg::*; (
  input  logic              clk,        // System clock.
  input  logic              srst,       // Synchronous reset.
  input  logic [AXI_AW-1:0] s_awaddr,   // Write address.
  input  logic              s_awvalid,  // Write address valid.
  output logic              s_awready,  // Write address ready.
  input  logic [31:0]       s_wdata,    // Write data.
  input  logic [3:0]        s_wstrb,    // Write byte strobes.
  input  logic              s_wvalid,   // Write data valid.
  output logic              s_wready,   // Write data ready.
  output logic [1:0]        s_bresp,    // Write response.
  output logic              s_bvalid,   // Write response valid.
  input  logic              s_bready,   // Write response ready.
  input  logic [AXI_AW-1:0] s_araddr,   // Read address.
  input  logic              s_arvalid,  // Read address valid.
  output logic              s_arready,  // Read address ready.
  output logic [31:0]       s_rdata,    // Read data.
  output logic [1:0]        s_rresp,    // Read response.
  output logic              s_rvalid,   // Read data valid.
  input  logic              s_rready,   // Read data ready.
  output logic              reg_wr,     // Register write strobe.
  output logic [AXI_AW-1:0] reg_waddr,  // Register write address.
  output logic [31:0]       reg_wdata,  // Register write data.
  output logic [3:0]        reg_wstrb,  // Register write byte lanes.
  input  logic              wr_ok,      // Write address is writable.
  output logic [AXI_AW-1:0] reg_raddr,  // Register read address.
  input  logic [31:0]       rd_data,    // Read data for reg_raddr.
  input  logic              rd_ok       // Read address is mapped.
);

  logic aw_held;
  logic w_held;

  assign s_awready = ~aw_held & ~s_bvalid;
  assign s_wready  = ~w_held & ~s_bvalid;
  assign s_arready = ~s_rvalid;
  assign reg_wr    = aw_held & w_held & ~s_bvalid;
  assign reg_raddr = s_araddr;

  // Address and data are parked independently, so either may come first.
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      reg_waddr <= '0;
      reg_wdata <= '0;
      reg_wstrb <= '0;
      s_bvalid  <= 1'b0;
      s_bresp   <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held   <= 1'b1;
        reg_waddr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held    <= 1'b1;
        reg_wdata <= s_wdata;
        reg_wstrb <= s_wstrb;
      end
      if (reg_wr) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_rvalid <= 1'b0;
      s_rdata  <= '0;
      s_rresp  <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_ok ? rd_data : 32'h0000_0000;
      s_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule // ias_axil_slave

// ### verif/ias_reader.sv
// Behavioural tape reader model that delivers one character per strobe.
module ias_reader (
  input  logic       clk,    // System clock.
  output logic       strobe, // Character strobe.
  output logic [4:0] chr     // Holes, bit 4 space.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    strobe = 1'b0;
    chr    = 5'h00;
  end
  // Holes settle well before the strobe and are scrambled two cycles after it drops,
  // so a loader that samples late sees garbage instead of a stale value.
  task automatic send(input logic [4:0] c);
    chr <= c;
    repeat (4) @(posedge clk);
    strobe <= 1'b1;
    repeat (4) @(posedge clk);
    strobe <= 1'b0;
    repeat (2) @(posedge clk);
    chr <= ~c;
    repeat (2) @(posedge clk);
  endtask
endmodule // ias_reader

// ### verif/tb_ias_sequencer.sv
// Self-checking bench of the instruction address sequencer.
module tb_ias_sequencer import ias_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, srst, awv, wv, br, arv, rr, awr, wr, bv, arr, rv;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, d;
  logic [1:0]  bre, rre, r, sw;
  logic [9:0]  sel, xa, lights;
  logic        ld, stp, xv, adv, fr, ds, dst, dw, iv, dd, la, mc, rs;
  logic [39:0] dwd, ihr, drd;
  logic [4:0]  rc;
  int          failures, tests_run;
  ias_sequencer dut (.clk(clk), .srst(srst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bre), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rre),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .sel_sw(sel),
    .set_counter_sw(sw[0]), .mem_clear_sw(sw[1]), .load_sw(ld),
    .reader_strobe(rs), .reader_char(rc), .machine_stopped(stp),
    .xfer_valid(xv), .xfer_addr(xa), .advance_req(adv), .fetch_req(fr),
    .drum_start(ds), .drum_step(dst), .drum_wr(dw), .drum_wdata(dwd),
    .counter_lights(lights), .instruction_holding_register(ihr),
    .ihr_valid(iv), .drum_rdata(drd), .drum_done(dd),
    .load_active(la), .mem_clearing(mc));
  ias_reader rdr (.clk(clk), .strobe(rs), .chr(rc));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task axr(input logic [7:0] a);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    @(posedge clk iff arr); arv <= 1'b0;
    @(posedge clk iff rv); d = rd; r = rre; rr <= 1'b0;
  endtask
  task axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    fork
      begin @(posedge clk iff awr); awv <= 1'b0; end
      begin @(posedge clk iff wr); wv <= 1'b0; end
    join
    @(posedge clk iff bv); r = bre; br <= 1'b0;
  endtask
  task press(input int i);
    sw[i] <= 1'b1; tick(4); sw[i] <= 1'b0; tick(4);
  endtask
  task step;
    adv <= 1'b1; tick(1); adv <= 1'b0; tick(1);
  endtask
  task xfer(input logic [9:0] a);
    xa <= a; xv <= 1'b1; tick(1); xv <= 1'b0; tick(1);
  endtask
  task fetch(input logic [39:0] e);
    fr <= 1'b1; tick(1); fr <= 1'b0; #1;
    chk(iv, 1'b1);
    chk(ihr, e);
    tick(1);
  endtask
  task send_word(input logic [39:0] w);
    for (int k = 9; k >= 0; k--) rdr.send({1'b0, w[4*k+:4]});
  endtask
  task t_panel;
    sel <= 10'h3ff; stp <= 1'b0; press(0);
    chk(lights, 10'h000);
    stp <= 1'b1; press(0);
    chk(lights, 10'h3ff);
    step; chk(lights, 10'h000);
    step; chk(lights, 10'h001);
  endtask
  task t_xfer;
    xfer(10'h155); chk(lights, 10'h155);
    axr(REG_COUNTER); chk(d, 32'h0000_0155);
    chk(r, RESP_OKAY);
  endtask
  task t_clear;
    press(1); chk(mc, 1'b1);
    for (int k = 0; k < 1100 && mc !== 1'b0; k++) tick(1);
    fetch(40'h00_0000_0000);
    chk(lights, 10'h155);
  endtask
  // The second pass reads back, through the drum port, what the first wrote.
  task t_drum;
    for (int p = 0; p < 2; p++) begin
      ds <= 1'b1; tick(1); ds <= 1'b0;
      for (int i = 0; i < 50; i++) begin
        dst <= 1'b1; dw <= (p == 0); dwd <= 40'(i); tick(1); dst <= 1'b0; #1;
        chk(dd, i == 49);
        if (p == 1) chk(drd, 40'(i));
        tick(1);
      end
    end
    dw <= 1'b0; chk(lights, 10'h155);
    xfer(10'h186); fetch(40'h00_0000_0031);
  endtask
  // The lone space between the words must not end the load.
  task t_load;
    sel <= 10'h200; press(0); ld <= 1'b1; tick(4);
    chk(la, 1'b1);
    send_word(40'h12_3456_789a); rdr.send(5'h10);
    send_word(40'hfe_dcba_9876); rdr.send(5'h10); rdr.send(5'h10);
    for (int k = 0; k < 50 && la !== 1'b0; k++) tick(1);
    chk(la, 1'b0);
    chk(lights, 10'h200);
    ld <= 1'b0; tick(1);
    fetch(40'h12_3456_789a);
    step; fetch(40'hfe_dcba_9876);
    ld <= 1'b1; tick(6); chk(la, 1'b1);
    ld <= 1'b0; tick(6); chk(la, 1'b0);
    chk(lights, 10'h201);
  endtask
  task t_axi;
    axr(8'h20); chk(r, RESP_SLVERR); chk(d, 32'h0000_0000);
    axr(REG_STATUS); chk(d, 32'h0000_0008);
    axw(REG_COUNTER, 32'h0000_0000); chk(r, RESP_SLVERR);
    chk(lights, 10'h201);
    axw(REG_PEEK_ADDR, 32'h0000_0186); chk(r, RESP_OKAY);
    axr(REG_PEEK_LO); chk(d, 32'h0000_0031);
    axr(REG_PEEK_HI); chk(d, 32'h0000_0000);
    axw(REG_CTRL, 32'h0000_0000); chk(r, RESP_OKAY);
    axr(REG_CTRL); chk(d, 32'h0000_0000);
    press(0); chk(lights, 10'h201);
  endtask
  initial begin
    {awa, ara, awv, wv, br, arv, rr, wd, sel, xa, sw} = '0;
    {ld, xv, adv, fr, ds, dst, dw, dwd} = '0;
    stp = 1'b1; srst = 1'b1; failures = 0; tests_run = 0;
    tick(4); srst <= 1'b0; tick(3);
    chk(lights, 10'h000);
    t_panel; t_xfer; t_clear; t_drum; t_load; t_axi;
    close_out;
  end
  initial begin
    tick(20000);
    failures++;
    close_out;
  end
endmodule // tb_ias_sequencer
